//--- rtl/pm_cap_defines.svh
// offsets, field positions, fixed values and timing of the pm capability
`ifndef PM_CAP_DEFINES_SVH
`define PM_CAP_DEFINES_SVH

// ---------------------------------------------------------------
// configuration space offsets (byte addresses) and dword index
// ---------------------------------------------------------------
`define PM_CAP_ID_OFFSET       8'hA0
`define PM_NEXT_PTR_OFFSET     8'hA1
`define PM_CAPS_OFFSET         8'hA2
`define PM_CAP_DWORD_INDEX     6'h28

// ---------------------------------------------------------------
// fixed register values
// ---------------------------------------------------------------
`define PM_CAP_ID_VALUE        8'h01
`define PM_NEXT_PTR_VALUE      8'h00
`define PM_CAPS_RESET          16'h7E21

// ---------------------------------------------------------------
// power capabilities word: field positions and values
// ---------------------------------------------------------------
`define PM_PME_MASK_MSB        15
`define PM_PME_MASK_LSB        11
`define PM_PME_MASK_VALUE      5'h0F
`define PM_D2_BIT              10
`define PM_D2_VALUE            1'h1
`define PM_D1_BIT              9
`define PM_D1_VALUE            1'h1
`define PM_RSVD_MSB            8
`define PM_RSVD_LSB            6
`define PM_RSVD_VALUE          3'h0
`define PM_DSI_BIT             5
`define PM_DSI_VALUE           1'h1
`define PM_AUX_BIT             4
`define PM_AUX_VALUE           1'h0
`define PM_PME_NEEDS_HOST_CLOCK_BIT          3
`define PM_PME_NEEDS_HOST_CLOCK_VALUE        1'h0
`define PM_VERSION_MSB         2
`define PM_VERSION_LSB         0
`define PM_VERSION_VALUE       3'h1

// ---------------------------------------------------------------
// dword byte lanes and answer timing
// ---------------------------------------------------------------
`define PM_LANE_ID_LSB         0
`define PM_LANE_NEXT_LSB       8
`define PM_LANE_CAPS_LSB       16
`define PM_ANSWER_CYCLES       1

`endif

//--- rtl/pm_cap_pkg.sv
// types shared by the pm capability register block
package pm_cap_pkg;

    // ---------------------------------------------------------------
    // configuration access sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ANSWER = 2'b01
    } cfg_state_e;

    typedef logic [7:0]  cfg_byte_t;
    typedef logic [15:0] cfg_half_t;
    typedef logic [31:0] cfg_dword_t;

endpackage

//--- rtl/pm_cap_word_build.sv
// assembles the fixed power-management capability dword from its fields
`timescale 1ns/1ps
`include "pm_cap_defines.svh"

module pm_cap_word_build
    import pm_cap_pkg::*;
(
    output cfg_half_t  o_caps_word,   // power capabilities word
    output cfg_dword_t o_cap_dword    // id, pointer and caps in one dword
);

    // ---------------------------------------------------------------
    // capability word fields
    // ---------------------------------------------------------------
    wire [4:0] pme_state_mask      = `PM_PME_MASK_VALUE;
    wire       pme_from_d3cold     = pme_state_mask[4];
    wire [3:0] pme_from_d3hot_to_d0 = pme_state_mask[3:0];
    wire       d2_state_supported  = `PM_D2_VALUE;
    wire       d1_state_supported  = `PM_D1_VALUE;
    wire [2:0] reserved_bits       = `PM_RSVD_VALUE;
    wire       dev_specific_init   = `PM_DSI_VALUE;
    wire       aux_power_flag      = `PM_AUX_VALUE;
    wire       pme_needs_host_clock = `PM_PME_NEEDS_HOST_CLOCK_VALUE;
    wire [2:0] pm_version          = `PM_VERSION_VALUE;

    // packed in field order, msb first; the result must equal 7E21h
    assign o_caps_word = {pme_from_d3cold, pme_from_d3hot_to_d0,
                          d2_state_supported, d1_state_supported,
                          reserved_bits, dev_specific_init,
                          aux_power_flag, pme_needs_host_clock,
                          pm_version};

    // lane 0 id, lane 1 next pointer, lanes 3:2 capabilities
    assign o_cap_dword = {o_caps_word,
                          cfg_byte_t'(`PM_NEXT_PTR_VALUE),
                          cfg_byte_t'(`PM_CAP_ID_VALUE)};

endmodule

//--- rtl/pci_pm_capability_regs.sv
// read-only power-management capability registers in config space
//
// Operation
// - next-item pointer byte at A1h always reads 00h, single list entry.
// - pme state mask, bits 15..11, reads 01111b.
// - bit 15 reads 0: no pme from d3cold.
// - bits 14..11 read 1: pme from d3hot, d2, d1 and d0.
// - d2 supported flag, bit 10, always reads 1.
// - d1 supported flag, bit 9, always reads 1.
// - reserved bits 8..6 always read 000b.
// - bit 5 reads 1: device-specific initialisation is needed.
// - aux power flag, bit 4, reads 0: own auxiliary supply.
// - pme host clock flag, bit 3, reads 0: no clock needed.
// - version field, bits 2..0, reads 001b.
// - capability id byte at A0h reads 01h.
`timescale 1ns/1ps
`include "pm_cap_defines.svh"

module pci_pm_capability_regs
    import pm_cap_pkg::*;
#(
    parameter int DATA_W = 32           // config data path width
)(
    input  wire logic        i_sys_clk,    // pci clock, 10 mhz
    input  wire logic        i_reset_n,    // pci reset, async, active low
    input  wire logic        i_cfg_req,    // config access strobe, pulse
    input  wire logic        i_cfg_we,     // 1 write, 0 read
    input  wire logic [7:0]  i_cfg_addr,   // config byte address
    input  wire logic [3:0]  i_cfg_be,     // byte enables, active high
    input  wire logic [31:0] i_cfg_wdata,  // write data, discarded
    output logic             o_cfg_ack,    // access answered, pulse
    output logic             o_cfg_hit,    // access fell on this dword
    output logic [31:0]      o_cfg_rdata,  // read data, valid with ack
    output logic [15:0]      o_caps_word   // capabilities word, steady
);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // the lane layout is fixed to one 32-bit config dword
    generate
        if (DATA_W != 32) begin : g_bad_width
            $error("pm capability block needs a 32-bit data path");
        end
    endgenerate

    // ---------------------------------------------------------------
    // fixed-pattern consistency checks
    // ---------------------------------------------------------------
    // the reset word and the per-field values are kept apart; if one
    // is edited without the other, the steady word would jump from one
    // pattern to the other on the first clock after reset, so both
    // descriptions are held against each other before anything runs
    localparam cfg_half_t  CAPS_RESET = `PM_CAPS_RESET;
    localparam cfg_byte_t  ID_OFFSET  = `PM_CAP_ID_OFFSET;

    // field by field, the reset word must match the built pattern
    generate
        if (CAPS_RESET[`PM_PME_MASK_MSB:`PM_PME_MASK_LSB]
                != `PM_PME_MASK_VALUE) begin : g_bad_pme
            $error("reset word disagrees with the pme state mask");
        end
        if (CAPS_RESET[`PM_D2_BIT] != `PM_D2_VALUE) begin : g_bad_d2
            $error("reset word disagrees with the d2 flag");
        end
        if (CAPS_RESET[`PM_D1_BIT] != `PM_D1_VALUE) begin : g_bad_d1
            $error("reset word disagrees with the d1 flag");
        end
        if (CAPS_RESET[`PM_RSVD_MSB:`PM_RSVD_LSB]
                != `PM_RSVD_VALUE) begin : g_bad_rsvd
            $error("reset word sets reserved bits");
        end
        if (CAPS_RESET[`PM_DSI_BIT] != `PM_DSI_VALUE) begin : g_bad_dsi
            $error("reset word disagrees with the init flag");
        end
        if (CAPS_RESET[`PM_AUX_BIT] != `PM_AUX_VALUE) begin : g_bad_aux
            $error("reset word disagrees with the aux power flag");
        end
        if (CAPS_RESET[`PM_PME_NEEDS_HOST_CLOCK_BIT] != `PM_PME_NEEDS_HOST_CLOCK_VALUE) begin : g_bad_clk
            $error("reset word disagrees with the host clock flag");
        end
        if (CAPS_RESET[`PM_VERSION_MSB:`PM_VERSION_LSB]
                != `PM_VERSION_VALUE) begin : g_bad_ver
            $error("reset word disagrees with the version field");
        end
    endgenerate

    // the decode claims one aligned dword and serves its bytes as lanes
    generate
        if (ID_OFFSET[1:0] != 2'b00) begin : g_bad_align
            $error("capability id must open an aligned dword");
        end
        if (ID_OFFSET[7:2] != `PM_CAP_DWORD_INDEX) begin : g_bad_index
            $error("dword index does not match the id offset");
        end
        if (`PM_NEXT_PTR_OFFSET != ID_OFFSET + 8'h01) begin : g_bad_next
            $error("next pointer must follow the id byte");
        end
        if (`PM_CAPS_OFFSET != ID_OFFSET + 8'h02) begin : g_bad_caps
            $error("capabilities word must follow the next pointer");
        end
        if (`PM_LANE_NEXT_LSB != `PM_LANE_ID_LSB + 8) begin : g_bad_lane1
            $error("next pointer lane out of place");
        end
        if (`PM_LANE_CAPS_LSB != `PM_LANE_ID_LSB + 16) begin : g_bad_lane2
            $error("capabilities lanes out of place");
        end
        // the sequencer has a single answer state, so it cannot stretch
        if (`PM_ANSWER_CYCLES != 1) begin : g_bad_latency
            $error("sequencer answers after exactly one cycle");
        end
    endgenerate

    // ---------------------------------------------------------------
    // fixed contents
    // ---------------------------------------------------------------
    cfg_half_t  caps_word;
    cfg_dword_t cap_dword;
    // sequencer state, declared here since the decode below reads it
    cfg_state_e state_q;
    cfg_state_e state_d;

    pm_cap_word_build u_word_build (
        .o_caps_word (caps_word),
        .o_cap_dword (cap_dword)
    );

    // ---------------------------------------------------------------
    // request decode
    // ---------------------------------------------------------------
    // dword at A0h as the requester sees it:
    //   lane 0 (bits 7:0)    capability id, 01h
    //   lane 1 (bits 15:8)   next-item pointer, 00h
    //   lanes 3:2 (31:16)    power capabilities word, 7E21h
    // neighbouring dwords belong to other registers and are not claimed
    // only the dword holding A0h..A3h is claimed; the low two address
    // bits and the byte enables pick lanes, not registers
    wire dword_hit   = (i_cfg_addr[7:2] == `PM_CAP_DWORD_INDEX);
    wire lane_id     = i_cfg_be[0];
    wire lane_next   = i_cfg_be[1];
    wire lane_caps   = i_cfg_be[2] | i_cfg_be[3];
    wire any_lane    = lane_id | lane_next | lane_caps;

    // a write is acked with zero read data and stores nothing, so the read
    // values can never drift from the fixed pattern
    wire take_req    = i_cfg_req & (state_q == ST_IDLE);
    wire take_read   = take_req & ~i_cfg_we;
    wire take_write  = take_req & i_cfg_we;
    wire write_drop  = take_write & dword_hit & any_lane;

    // ---------------------------------------------------------------
    // read data selection
    // ---------------------------------------------------------------
    // the full dword is returned whatever the byte enables say; the
    // requester keeps only the lanes it asked for
    wire [31:0] read_word = (take_read && dword_hit) ? cap_dword : 32'h0;
    wire [31:0] rdata_d   = read_word;
    wire        hit_d     = take_req & dword_hit;

    // ---------------------------------------------------------------
    // access sequencer
    // ---------------------------------------------------------------
    // every taken access is answered exactly one cycle later; a strobe
    // in the answer cycle is not taken, which keeps answers in order

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take_req) begin
                    state_d = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire ack_d = (state_d == ST_ANSWER);

    // ---------------------------------------------------------------
    // state and answer flops
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // answer outputs come straight from flops
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cfg_ack   <= 1'b0;
            o_cfg_hit   <= 1'b0;
            o_cfg_rdata <= 32'h0;
        end else begin
            o_cfg_ack   <= ack_d;
            o_cfg_hit   <= hit_d;
            o_cfg_rdata <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // steady capability word
    // ---------------------------------------------------------------
    // reset loads the documented constant; afterwards the flop keeps
    // the built pattern, and a dropped write has no path into it
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_caps_word <= `PM_CAPS_RESET;
        end else begin
            o_caps_word <= caps_word;
        end
    end

    // write data and the drop flag are deliberately left unread beyond
    // this point: the registers are read-only
    wire unused_ok = ^{i_cfg_wdata, write_drop, i_cfg_addr[1:0]};

endmodule

//--- test/pm_cap_assertions.sv
// concurrent checks on the pm capability register block ports
`timescale 1ns/1ps

module pm_cap_checker (
    input wire logic        i_sys_clk,   // pci clock
    input wire logic        i_reset_n,   // pci reset, active low
    input wire logic        i_cfg_req,   // access strobe
    input wire logic        i_cfg_we,    // write select
    input wire logic [7:0]  i_cfg_addr,  // byte address
    input wire logic [3:0]  i_cfg_be,    // byte enables
    input wire logic [31:0] i_cfg_wdata, // write data
    input wire logic        o_cfg_ack,   // answer strobe
    input wire logic        o_cfg_hit,   // dword claimed
    input wire logic [31:0] o_cfg_rdata, // read data
    input wire logic [15:0] o_caps_word  // capabilities word
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // a request taken while idle is answered on the very next edge
    AST_ACK_NEXT: assert property (
        i_cfg_req && !o_cfg_ack |=> o_cfg_ack)
        else $error("request not answered next cycle");
    AST_ACK_ONE: assert property (o_cfg_ack |=> !o_cfg_ack)
        else $error("ack longer than one cycle");
    AST_READ_DWORD: assert property (
        o_cfg_ack && o_cfg_hit && !$past(i_cfg_we)
        |-> o_cfg_rdata == 32'h7E210001) else $error("bad read dword");
    AST_WRITE_QUIET: assert property (o_cfg_ack && $past(i_cfg_we)
        |-> o_cfg_rdata == 32'h0) else $error("write returned data");
    AST_HIT_DECODE: assert property (o_cfg_ack
        |-> o_cfg_hit == ($past(i_cfg_addr[7:2]) == 6'h28))
        else $error("hit does not follow address");
    AST_PME_MASK: assert property (
        o_caps_word[15:11] == 5'h0F)
        else $error("pme state mask wrong");
    AST_D_STATES: assert property (
        o_caps_word[10:9] == 2'h3)
        else $error("d1 or d2 flag wrong");
    AST_RSVD_ZERO: assert property (o_caps_word[8:6] == 3'h0)
        else $error("reserved bits set");
    AST_LOW_FIELDS: assert property (
        o_caps_word[5:0] == 6'h21)
        else $error("low capability fields wrong");
endmodule

bind pci_pm_capability_regs pm_cap_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cfg_req(i_cfg_req),
    .i_cfg_we(i_cfg_we), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(o_cfg_ack), .o_cfg_hit(o_cfg_hit),
    .o_cfg_rdata(o_cfg_rdata), .o_caps_word(o_caps_word));

//--- test/pci_pm_capability_regs_tb.sv
// self-checking bench for the pm capability register block
`timescale 1ns/1ps

module pci_pm_capability_regs_tb;
    logic        i_sys_clk, i_reset_n, i_cfg_req, i_cfg_we, o_cfg_ack;
    logic        o_cfg_hit, hit;
    logic [7:0]  i_cfg_addr;
    logic [3:0]  i_cfg_be;
    logic [31:0] i_cfg_wdata, o_cfg_rdata, rd;
    logic [15:0] o_caps_word;
    int          n_fail = 0;
    int          checks = 0;

    pci_pm_capability_regs uut (.i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n), .i_cfg_req(i_cfg_req), .i_cfg_we(i_cfg_we),
        .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(o_cfg_ack),
        .o_cfg_hit(o_cfg_hit), .o_cfg_rdata(o_cfg_rdata),
        .o_caps_word(o_caps_word));

    // 100 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    task final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one request, held until the answer is seen, released after it
    task access(input logic we, input logic [7:0] a, input logic [3:0] be);
        int n;
        @(posedge i_sys_clk);
        i_cfg_req <= 1'b1;
        i_cfg_we <= we;
        i_cfg_addr <= a;
        i_cfg_be <= be;
        n = 0;
        @(posedge i_sys_clk);
        #1;
        while (o_cfg_ack !== 1'b1 && n < 8) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (n == 8) begin
            n_fail++;
            $display("unexpected at %0t: no answer", $time);
            final_report();
        end else begin
            rd = o_cfg_rdata;
            hit = o_cfg_hit;
            // the answer stands to the next edge; release only there
            @(posedge i_sys_clk);
            i_cfg_req <= 1'b0;
        end
    endtask

    task t_fields;
        check(32'(o_caps_word[15:11]), 32'h0F);
        check(32'(o_caps_word[15]), 32'h0);
        check(32'(o_caps_word[14:11]), 32'hF);
        check(32'(o_caps_word[10]), 32'h1);
        check(32'(o_caps_word[9]), 32'h1);
        check(32'(o_caps_word[8:6]), 32'h0);
        check(32'(o_caps_word[5]), 32'h1);
        check(32'(o_caps_word[4]), 32'h0);
        check(32'(o_caps_word[3]), 32'h0);
        check(32'(o_caps_word[2:0]), 32'h1);
    endtask

    // every byte of the dword and every lane enable returns the whole dword
    task t_reads;
        for (int i = 0; i < 4; i++) begin
            access(1'b0, 8'(8'hA0 + i), 4'(4'h1 << i));
            check(rd, 32'h7E210001);
            check(32'(rd[15:8]), 32'h0);
            check(32'(hit), 32'h1);
        end
    endtask

    // writes of all ones are acked, then nothing has moved
    task t_writes;
        @(posedge i_sys_clk);
        i_cfg_wdata <= 32'hFFFFFFFF;
        for (int i = 1; i < 4; i++) begin
            access(1'b1, 8'(8'hA0 + i), 4'hF);
            check(rd, 32'h0);
            check(32'(hit), 32'h1);
        end
        access(1'b0, 8'hA0, 4'hF);
        check(rd, 32'h7E210001);
        t_fields();
    endtask

    // the dword below is not claimed; the dword above reads zero
    task t_unmapped;
        access(1'b0, 8'h9C, 4'hF);
        check({31'h0, hit}, 32'h0);
        access(1'b0, 8'hA4, 4'hF);
        check(rd, 32'h0);
    endtask

    // a strobe held into the answer cycle must not give a second answer
    task t_refused;
        @(posedge i_sys_clk);
        i_cfg_req <= 1'b1;
        i_cfg_we <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        check(32'(o_cfg_ack), 32'h1);
        @(posedge i_sys_clk);
        i_cfg_req <= 1'b0;
        #1;
        check(32'(o_cfg_ack), 32'h0);
        @(posedge i_sys_clk);
        #1;
        check(32'(o_cfg_ack), 32'h0);
    endtask

    initial begin
        i_reset_n = 1'b0;
        i_cfg_req = 1'b0;
        i_cfg_we = 1'b0;
        i_cfg_addr = 8'hA0;
        i_cfg_be = 4'hF;
        i_cfg_wdata = 32'h0;
        repeat (16) @(posedge i_sys_clk);
        t_fields();
        i_reset_n <= 1'b1;
        t_reads();
        t_writes();
        t_unmapped();
        t_refused();
        // reset again in mid-run: the word must not waver
        @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        check(32'(o_caps_word), 32'h7E21);
        i_reset_n <= 1'b1;
        t_reads();
        final_report();
    end
endmodule
